// ### shared/mfa_cfg.svh
// Register map, field positions and reset values of the fault-alert block
`ifndef MFA_CFG_SVH
`define MFA_CFG_SVH

// ****************************************
// Command addresses
// ****************************************
`define MFA_ADDR_MEAS_FIRST 8'h20
`define MFA_ADDR_MEAS_LAST 8'h24
`define MFA_ADDR_VLIM_FIRST 8'h2B
`define MFA_ADDR_VLIM_LAST 8'h32
`define MFA_ADDR_HOT 8'h39
`define MFA_ADDR_HYST 8'h3A
`define MFA_ADDR_CFG 8'h40
`define MFA_ADDR_STATUS 8'h41
`define MFA_ADDR_MASK 8'h43
`define MFA_ADDR_TCFG 8'h4C

// ****************************************
// Reset values
// ****************************************
`define MFA_RST_HOT 8'h50
`define MFA_RST_HYST 8'h41
`define MFA_RST_VOLTAGE_HIGH_LIMIT 8'hD3
`define MFA_RST_VOLTAGE_LOW_LIMIT 8'hAD
`define MFA_RST_CFG 8'h00
`define MFA_RST_TCFG 8'h00
`define MFA_RST_STATUS 8'h00
`define MFA_RST_MASK 8'h00

// ****************************************
// Field positions
// ****************************************
`define MFA_CFG_START 0
`define MFA_CFG_INT_EN 1
`define MFA_CFG_INT_CLR 3
`define MFA_CFG_LINE_SEL 4
`define MFA_CFG_SHORT 5
`define MFA_CFG_SOFT_RST 7
`define MFA_TEMP_BIT 4
`define MFA_TEMP_CHAN 3'h4
`define MFA_STATUS_USED 8'h1F
`define MFA_TMODE_ONE_TIME 2'h1
`define MFA_TMODE_COMPARE 2'h2

`endif

// ### shared/mfa_pkg.sv
// Types shared by the fault-alert block
package mfa_pkg;

	typedef enum logic [1:0] {MFA_CMD_WRITE, MFA_CMD_READ, MFA_CMD_CLEAR} mfa_cmd_t;

	typedef enum logic [1:0] {MFA_TM_DEFAULT, MFA_TM_ONE_TIME, MFA_TM_COMPARE} mfa_tmode_t;

	typedef enum logic [1:0] {MFA_LK_IDLE, MFA_LK_WAIT} mfa_link_state_t;

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] tcfg;
		logic [7:0] hot;
		logic [7:0] hyst;
		logic [7:0] mask;
		logic [7:0] status;
		logic [7:0][7:0] vlim;
		logic [4:0][7:0] meas;
	} mfa_regs_t;

	typedef struct packed {
		mfa_regs_t regs;
		logic req_s1;
		logic req_s2;
		logic req_s3;
		logic ack_tgl;
		logic [7:0] rdata;
		logic [4:0] alert_src;
		logic temp_armed;
		logic cmp_hot;
		logic [7:0] snap;
		logic snap_valid;
		logic alert_oe;
	} mfa_core_t;

	typedef struct packed {
		mfa_link_state_t state;
		logic req_tgl;
		mfa_cmd_t cmd;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic ack_s1;
		logic ack_s2;
		logic rsp_valid;
		logic [7:0] rsp_data;
	} mfa_link_t;

endpackage

// ### shared/mfa_xfer_if.sv
// Request and answer carrier between link front end and core register file
`timescale 1ns/1ps
interface mfa_xfer_if;
	logic req_tgl;
	mfa_pkg::mfa_cmd_t cmd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic ack_tgl;
	logic [7:0] rdata;

	modport link (output req_tgl, output cmd, output addr, output wdata, input ack_tgl, input rdata);
	modport core (input req_tgl, input cmd, input addr, input wdata, output ack_tgl, output rdata);
endinterface

// ### verilog/mfa_link_front.sv
// Link-clock front end: takes register commands and passes them to the core by toggle handshake
`timescale 1ns/1ps
module mfa_link_front (
	// Clock and reset
	input wire logic i_link_clk,
	input wire logic i_nrst,
	// Command port
	input wire logic i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic [7:0] i_cmd_addr,
	input wire logic [7:0] i_cmd_wdata,
	input wire logic i_rd_done,
	output logic o_cmd_ready,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_data,
	// Toward core
	mfa_xfer_if.link xfer
);

	mfa_pkg::mfa_link_t r;
	mfa_pkg::mfa_link_t next_r;

	always_comb begin
		next_r = r;
		next_r.ack_s1 = xfer.ack_tgl;
		next_r.ack_s2 = r.ack_s1;
		next_r.rsp_valid = 1'b0;
		case (r.state)
			mfa_pkg::MFA_LK_IDLE: begin
				// End of a shifted-out byte wins over a new command in the same cycle
				if (i_rd_done) begin
					next_r.cmd = mfa_pkg::MFA_CMD_CLEAR;
					next_r.req_tgl = ~r.req_tgl;
					next_r.state = mfa_pkg::MFA_LK_WAIT;
				end else if (i_cmd_valid) begin
					next_r.cmd = i_cmd_write ? mfa_pkg::MFA_CMD_WRITE : mfa_pkg::MFA_CMD_READ;
					next_r.addr = i_cmd_addr;
					next_r.wdata = i_cmd_wdata;
					next_r.req_tgl = ~r.req_tgl;
					next_r.state = mfa_pkg::MFA_LK_WAIT;
				end
			end
			default: begin
				// Answer data was registered with the ack toggle, two flops back, so it is stable here
				if (r.ack_s2 == r.req_tgl) begin
					next_r.rsp_valid = (r.cmd == mfa_pkg::MFA_CMD_READ);
					next_r.rsp_data = xfer.rdata;
					next_r.state = mfa_pkg::MFA_LK_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_link_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign xfer.req_tgl = r.req_tgl;
	assign xfer.cmd = r.cmd;
	assign xfer.addr = r.addr;
	assign xfer.wdata = r.wdata;
	assign o_cmd_ready = (r.state == mfa_pkg::MFA_LK_IDLE);
	assign o_rsp_valid = r.rsp_valid;
	assign o_rsp_data = r.rsp_data;

endmodule

// ### verilog/mfa_fault_alert.sv
// Fault-alert logic: limit compare, fault status, mask and open-drain alert
`timescale 1ns/1ps
`include "mfa_cfg.svh"
// Operation
// - Status bits 0-3 flag low, high, mid rail and supply faults; bit 4 temperature.
// - A set mask bit blocks its status bit and its alert source.
// - Voltage limits live at 2Bh-32h; below low or above high raises alert.
// - Hot limit at 39h, hysteresis at 3Ah; above hot raises alert.
// - Hot limit resets to 50h, hysteresis to 41h, signed degrees.
// - Voltage high limits reset to 1.1x, low to 0.9x nominal code.
// - Default and one-time modes: status read clears status until new fault.
// - Alert released by status read or config bit 3; status read spares comparator temperature alert.
// - Status read clears the bits it returned, except bit 4 in comparator mode.
// - Persisting voltage or default-mode temperature fault re-asserts alert at the next conversion result.
// - Config bit 1 low holds alert inactive; status still records.
// - Alert never stops conversions; measurement registers keep updating.
// - Alert is active-low open drain: pull low or float only.
// - Temperature status behaviour follows mode field in temperature config bits 1:0.
// - Mode 00 default, 01 one-time, 10 comparator, 11 default.
// - Default: above hot alerts each measurement until below hysteresis.
// - One-time: after cleared hot alert, next alert when below hysteresis.
// - Comparator: bit 4 and alert follow above-hot, immune to reads.
// - Config bit 0 low stops monitoring; register access still works.
// - During power-on reset registers hold defaults, shutdown, link silent.
// - Status and mask registers reset to 00h.
// - Config bit 3 set releases alert, keeps status, halts monitoring.
module mfa_fault_alert #(
	parameter int NUM_VIN = 4
) (
	// Clocks and reset
	input wire logic i_core_clk,
	input wire logic i_link_clk,
	input wire logic i_nrst,
	// Conversion results, core clock domain
	input wire logic i_meas_valid,
	input wire logic [2:0] i_meas_chan,
	input wire logic [7:0] i_meas_data,
	// Register command port, link clock domain
	input wire logic i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic [7:0] i_cmd_addr,
	input wire logic [7:0] i_cmd_wdata,
	input wire logic i_rd_done,
	output logic o_cmd_ready,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_data,
	// Converter control
	output logic o_monitor_run,
	output logic o_line_50hz,
	output logic o_short_cycle,
	// Alert pin
	output logic o_alert_n_out,
	output logic o_alert_oe
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	generate
		if (NUM_VIN != 4) begin : g_bad_vin
			$error("NUM_VIN must be 4: the status and mask layout has four voltage bits");
		end
	endgenerate

	localparam mfa_pkg::mfa_regs_t REGS_RST = '{
		cfg: `MFA_RST_CFG,
		tcfg: `MFA_RST_TCFG,
		hot: `MFA_RST_HOT,
		hyst: `MFA_RST_HYST,
		mask: `MFA_RST_MASK,
		status: `MFA_RST_STATUS,
		vlim: {NUM_VIN{`MFA_RST_VOLTAGE_LOW_LIMIT, `MFA_RST_VOLTAGE_HIGH_LIMIT}},
		meas: '0
	};

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic is_vlim(input logic [7:0] addr);
		is_vlim = (addr >= `MFA_ADDR_VLIM_FIRST) && (addr <= `MFA_ADDR_VLIM_LAST);
	endfunction

	function automatic logic is_meas(input logic [7:0] addr);
		is_meas = (addr >= `MFA_ADDR_MEAS_FIRST) && (addr <= `MFA_ADDR_MEAS_LAST);
	endfunction

	function automatic mfa_pkg::mfa_tmode_t decode_tmode(input logic [1:0] field);
		if (field == `MFA_TMODE_ONE_TIME) begin
			decode_tmode = mfa_pkg::MFA_TM_ONE_TIME;
		end else if (field == `MFA_TMODE_COMPARE) begin
			decode_tmode = mfa_pkg::MFA_TM_COMPARE;
		end else begin
			decode_tmode = mfa_pkg::MFA_TM_DEFAULT;
		end
	endfunction

	function automatic logic [7:0] read_reg(input mfa_pkg::mfa_regs_t regs, input logic [7:0] addr);
		logic [7:0] off;
		off = 8'h00;
		if (is_vlim(addr)) begin
			off = addr - `MFA_ADDR_VLIM_FIRST;
			read_reg = regs.vlim[off[2:0]];
		end else if (is_meas(addr)) begin
			off = addr - `MFA_ADDR_MEAS_FIRST;
			read_reg = regs.meas[off[2:0]];
		end else if (addr == `MFA_ADDR_HOT) begin
			read_reg = regs.hot;
		end else if (addr == `MFA_ADDR_HYST) begin
			read_reg = regs.hyst;
		end else if (addr == `MFA_ADDR_CFG) begin
			read_reg = regs.cfg;
		end else if (addr == `MFA_ADDR_STATUS) begin
			read_reg = regs.status;
		end else if (addr == `MFA_ADDR_MASK) begin
			read_reg = regs.mask;
		end else if (addr == `MFA_ADDR_TCFG) begin
			read_reg = regs.tcfg;
		end else begin
			read_reg = 8'h00;
		end
	endfunction

	// ****************************************
	// Link front end
	// ****************************************
	mfa_xfer_if xfer ();

	mfa_link_front u_link (
		.i_link_clk(i_link_clk),
		.i_nrst(i_nrst),
		.i_cmd_valid(i_cmd_valid),
		.i_cmd_write(i_cmd_write),
		.i_cmd_addr(i_cmd_addr),
		.i_cmd_wdata(i_cmd_wdata),
		.i_rd_done(i_rd_done),
		.o_cmd_ready(o_cmd_ready),
		.o_rsp_valid(o_rsp_valid),
		.o_rsp_data(o_rsp_data),
		.xfer(xfer)
	);

	mfa_pkg::mfa_core_t r;
	mfa_pkg::mfa_core_t next_r;

	// ****************************************
	// Per-channel voltage window compare
	// ****************************************
	logic [NUM_VIN-1:0] vfault;

	genvar gc;
	generate
		for (gc = 0; gc < NUM_VIN; gc++) begin : g_vcmp
			// Even index holds the high limit, odd the low limit
			assign vfault[gc] = (i_meas_data < r.regs.vlim[2*gc+1]) || (i_meas_data > r.regs.vlim[2*gc]);
		end
	endgenerate

	// ****************************************
	// Core state update
	// ****************************************
	mfa_pkg::mfa_tmode_t tmode;
	logic run;
	logic temp_hot;
	logic temp_cold;
	logic new_req;
	logic [7:0] set_bits;
	logic [7:0] clr_bits;
	logic [7:0] woff;
	logic alert_clr;

	assign tmode = decode_tmode(r.regs.tcfg[1:0]);
	// Config bit 3 halts the loop as long as it stays set
	assign run = r.regs.cfg[`MFA_CFG_START] & ~r.regs.cfg[`MFA_CFG_INT_CLR];
	assign temp_hot = $signed(i_meas_data) > $signed(r.regs.hot);
	assign temp_cold = $signed(i_meas_data) < $signed(r.regs.hyst);
	assign new_req = r.req_s2 ^ r.req_s3;

	always_comb begin
		next_r = r;
		set_bits = 8'h00;
		clr_bits = 8'h00;
		woff = 8'h00;
		alert_clr = 1'b0;
		next_r.req_s1 = xfer.req_tgl;
		next_r.req_s2 = r.req_s1;
		next_r.req_s3 = r.req_s2;

		// Results are stored even while alert is asserted or loop is stopped
		if (i_meas_valid) begin
			if (i_meas_chan < `MFA_TEMP_CHAN) begin
				next_r.regs.meas[i_meas_chan] = i_meas_data;
				set_bits[i_meas_chan] = run & vfault[i_meas_chan[1:0]];
			end else if (i_meas_chan == `MFA_TEMP_CHAN) begin
				next_r.regs.meas[`MFA_TEMP_BIT] = i_meas_data;
				if (run) begin
					case (tmode)
						mfa_pkg::MFA_TM_ONE_TIME: begin
							// Hot crossing arms; falling below hysteresis fires once more
							if (!r.temp_armed && temp_hot) begin
								set_bits[`MFA_TEMP_BIT] = 1'b1;
								next_r.temp_armed = 1'b1;
							end else if (r.temp_armed && temp_cold) begin
								set_bits[`MFA_TEMP_BIT] = 1'b1;
								next_r.temp_armed = 1'b0;
							end
						end
						mfa_pkg::MFA_TM_COMPARE: begin
							next_r.cmp_hot = temp_hot;
						end
						default: begin
							if (temp_hot) begin
								next_r.temp_armed = 1'b1;
							end else if (temp_cold) begin
								next_r.temp_armed = 1'b0;
							end
							set_bits[`MFA_TEMP_BIT] = temp_hot | (r.temp_armed & ~temp_cold);
						end
					endcase
				end
			end
		end
		set_bits = set_bits & ~r.regs.mask;

		if (new_req) begin
			// Ack follows the request toggle in the same cycle that the answer data is loaded
			next_r.ack_tgl = r.req_s2;
			case (xfer.cmd)
				mfa_pkg::MFA_CMD_WRITE: begin
					if (is_vlim(xfer.addr)) begin
						woff = xfer.addr - `MFA_ADDR_VLIM_FIRST;
						next_r.regs.vlim[woff[2:0]] = xfer.wdata;
					end else if (xfer.addr == `MFA_ADDR_HOT) begin
						next_r.regs.hot = xfer.wdata;
					end else if (xfer.addr == `MFA_ADDR_HYST) begin
						next_r.regs.hyst = xfer.wdata;
					end else if (xfer.addr == `MFA_ADDR_CFG) begin
						next_r.regs.cfg = xfer.wdata;
						// Bit 3 drops the latched alert without touching status
						alert_clr = xfer.wdata[`MFA_CFG_INT_CLR];
					end else if (xfer.addr == `MFA_ADDR_MASK) begin
						next_r.regs.mask = xfer.wdata & `MFA_STATUS_USED;
					end else if (xfer.addr == `MFA_ADDR_TCFG) begin
						next_r.regs.tcfg = xfer.wdata;
					end
				end
				mfa_pkg::MFA_CMD_READ: begin
					next_r.rdata = read_reg(r.regs, xfer.addr);
					if (xfer.addr == `MFA_ADDR_STATUS) begin
						next_r.snap = r.regs.status;
						next_r.snap_valid = 1'b1;
					end
				end
				default: begin
					// Only bits that were actually sent are cleared; later faults survive
					if (r.snap_valid) begin
						clr_bits = r.snap;
						alert_clr = 1'b1;
						next_r.snap_valid = 1'b0;
					end
				end
			endcase
		end

		if (tmode == mfa_pkg::MFA_TM_COMPARE) begin
			clr_bits[`MFA_TEMP_BIT] = 1'b0;
		end
		// A fault arriving with the clear wins over it
		next_r.regs.status = ((r.regs.status & ~clr_bits) | set_bits) & `MFA_STATUS_USED;
		next_r.alert_src = (alert_clr ? 5'h00 : r.alert_src) | set_bits[4:0];
		// Comparator temperature never latches; a source left over from another mode is dropped
		if (tmode == mfa_pkg::MFA_TM_COMPARE) begin
			next_r.regs.status[`MFA_TEMP_BIT] = next_r.cmp_hot & ~r.regs.mask[`MFA_TEMP_BIT];
			next_r.alert_src[`MFA_TEMP_BIT] = 1'b0;
		end

		if (new_req && xfer.cmd == mfa_pkg::MFA_CMD_WRITE && xfer.addr == `MFA_ADDR_CFG
				&& xfer.wdata[`MFA_CFG_SOFT_RST]) begin
			next_r.regs = REGS_RST;
			next_r.alert_src = 5'h00;
			next_r.temp_armed = 1'b0;
			next_r.cmp_hot = 1'b0;
			next_r.snap_valid = 1'b0;
		end

		// Comparator temperature alert follows the live condition, not the latch
		next_r.alert_oe = r.regs.cfg[`MFA_CFG_INT_EN] & ~r.regs.cfg[`MFA_CFG_INT_CLR]
			& ((|(r.alert_src & ~r.regs.mask[4:0]))
			| ((tmode == mfa_pkg::MFA_TM_COMPARE) & r.regs.status[`MFA_TEMP_BIT]));
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= '{regs: REGS_RST, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign xfer.ack_tgl = r.ack_tgl;
	assign xfer.rdata = r.rdata;
	assign o_monitor_run = run;
	assign o_line_50hz = r.regs.cfg[`MFA_CFG_LINE_SEL];
	assign o_short_cycle = r.regs.cfg[`MFA_CFG_SHORT];
	// Pin is only ever pulled low; release means float
	assign o_alert_n_out = 1'b0;
	assign o_alert_oe = r.alert_oe;

endmodule

// ### testbench/mfa_fault_alert_checker.sv
// Port-level assertions of the fault-alert block
`timescale 1ns/1ps
module mfa_fault_alert_checker #(
	parameter int NUM_VIN = 4
) (
	// Clocks and reset
	input wire logic i_core_clk,
	input wire logic i_link_clk,
	input wire logic i_nrst,
	// Watched ports
	input wire logic i_meas_valid,
	input wire logic i_cmd_valid,
	input wire logic i_rd_done,
	input wire logic o_cmd_ready,
	input wire logic o_rsp_valid,
	input wire logic [7:0] o_rsp_data,
	input wire logic o_monitor_run,
	input wire logic o_line_50hz,
	input wire logic o_alert_n_out,
	input wire logic o_alert_oe
);
	// ********
	// Core domain
	// ********
	drain_only_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) o_alert_n_out == 1'b0)
		else $error("alert pin driven high");
	reset_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		$rose(i_nrst) |-> !o_alert_oe && !o_monitor_run) else $error("active right after reset");
	ctrl_by_cmd_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		$changed({o_monitor_run, o_line_50hz}) |-> !o_cmd_ready) else $error("control moved without command");
	// A fresh alert needs a recent result or a command in flight
	alert_cause_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) $rose(o_alert_oe) |->
		$past(i_meas_valid, 1) || $past(i_meas_valid, 2) || $past(i_meas_valid, 3) || !o_cmd_ready)
		else $error("alert rose without cause");
	// ********
	// Link domain, plus covers of both domains
	// ********
	ready_drop_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		o_cmd_ready && (i_cmd_valid || i_rd_done) |=> !o_cmd_ready) else $error("command not taken");
	ready_back_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		$fell(o_cmd_ready) |-> ##[1:12] o_cmd_ready) else $error("command port stuck busy");
	rsp_pulse_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		o_rsp_valid |=> !o_rsp_valid && o_cmd_ready) else $error("answer pulse too long");
	rsp_busy_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		o_rsp_valid |-> o_cmd_ready) else $error("answer while port busy");
	data_hold_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		$changed(o_rsp_data) |-> o_rsp_valid) else $error("read data moved between answers");
	cover property (@(posedge i_core_clk) disable iff (!i_nrst) $rose(o_alert_oe));
	cover property (@(posedge i_core_clk) disable iff (!i_nrst) $fell(o_alert_oe));
	cover property (@(posedge i_link_clk) disable iff (!i_nrst) o_rsp_valid);
endmodule

bind mfa_fault_alert mfa_fault_alert_checker #(.NUM_VIN(NUM_VIN)) u_mfa_chk (.i_core_clk(i_core_clk),
	.i_link_clk(i_link_clk), .i_nrst(i_nrst), .i_meas_valid(i_meas_valid), .i_cmd_valid(i_cmd_valid),
	.i_rd_done(i_rd_done), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
	.o_monitor_run(o_monitor_run), .o_line_50hz(o_line_50hz), .o_alert_n_out(o_alert_n_out),
	.o_alert_oe(o_alert_oe));

// ### testbench/mfa_host_model.sv
// Host model: issues register commands and watches the shared alert line
`timescale 1ns/1ps
module mfa_host_model (
	// Link clock
	input wire logic i_link_clk,
	// Device command port
	input wire logic i_cmd_ready,
	input wire logic i_rsp_valid,
	input wire logic [7:0] i_rsp_data,
	input wire logic i_alert_oe,
	output logic o_cmd_valid,
	output logic o_cmd_write,
	output logic [7:0] o_cmd_addr,
	output logic [7:0] o_cmd_wdata,
	output logic o_rd_done,
	// Shared alert line
	output logic o_alert_line
);
	logic [7:0] last_rd;
	int stalls;

	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_write = 1'b0;
		o_cmd_addr = 8'h00;
		o_cmd_wdata = 8'h00;
		o_rd_done = 1'b0;
		last_rd = 8'h00;
		stalls = 0;
	end

	// Pull-up: the line only goes low while some device sinks it
	assign o_alert_line = i_alert_oe ? 1'b0 : 1'b1;

	// Kind 0 write, 1 read, 2 end of status read
	task automatic xfer(input int kind, input logic [7:0] a, input logic [7:0] d);
		int n;
		// A read that never answers leaves an unknown behind, which no compare accepts
		if (kind == 1) last_rd = 8'hXX;
		@(posedge i_link_clk);
		o_cmd_valid <= kind != 2;
		o_rd_done <= kind == 2;
		o_cmd_write <= kind == 0;
		o_cmd_addr <= a;
		o_cmd_wdata <= d;
		n = 0;
		do begin
			@(posedge i_link_clk);
			n++;
		end while (!i_cmd_ready && n < 40);
		if (!i_cmd_ready) begin
			stalls++;
			$display("BAD %0t command not taken", $time);
		end
		// Released fields carry garbage so stale values cannot pass
		o_cmd_valid <= 1'b0;
		o_rd_done <= 1'b0;
		o_cmd_addr <= ~a;
		o_cmd_wdata <= ~d;
		n = 0;
		do begin
			@(posedge i_link_clk);
			n++;
			if (i_rsp_valid) last_rd = i_rsp_data;
		end while (!i_cmd_ready && n < 40);
		if (!i_cmd_ready) begin
			stalls++;
			$display("BAD %0t command never answered", $time);
		end
	endtask
endmodule

// ### testbench/test_monitor_fault_alert_logic.sv
// Self-checking bench of the fault-alert block
`timescale 1ns/1ps
module test_monitor_fault_alert_logic;
	logic i_core_clk, i_link_clk, i_nrst, meas_valid;
	logic [2:0] meas_chan;
	logic [7:0] meas_data, cmd_addr, cmd_wdata, rsp_data;
	logic cmd_valid, cmd_write, rd_done, cmd_ready, rsp_valid, monitor_run, alert_oe, alert_line;
	logic line_50hz, short_cycle;
	int fail_count;
	int compares;

	mfa_fault_alert #(.NUM_VIN(4)) DUT (.i_core_clk(i_core_clk), .i_link_clk(i_link_clk), .i_nrst(i_nrst),
		.i_meas_valid(meas_valid), .i_meas_chan(meas_chan), .i_meas_data(meas_data), .i_cmd_valid(cmd_valid),
		.i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata), .i_rd_done(rd_done),
		.o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_monitor_run(monitor_run),
		.o_line_50hz(line_50hz), .o_short_cycle(short_cycle), .o_alert_n_out(), .o_alert_oe(alert_oe));
	mfa_host_model host (.i_link_clk(i_link_clk), .i_cmd_ready(cmd_ready), .i_rsp_valid(rsp_valid),
		.i_rsp_data(rsp_data), .i_alert_oe(alert_oe), .o_cmd_valid(cmd_valid), .o_cmd_write(cmd_write),
		.o_cmd_addr(cmd_addr), .o_cmd_wdata(cmd_wdata), .o_rd_done(rd_done), .o_alert_line(alert_line));

	initial begin
		i_core_clk = 1'b0;
		forever #2 i_core_clk = ~i_core_clk;
	end
	initial begin
		i_link_clk = 1'b0;
		#3.3;
		forever #7.5 i_link_clk = ~i_link_clk;
	end

	// ********
	// Helpers
	// ********
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		host.xfer(1, a, 8'h00);
		check(host.last_rd, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.xfer(0, a, d);
	endtask
	task automatic clr();
		host.xfer(2, 8'h00, 8'h00);
	endtask
	task automatic alert(input logic exp);
		check({7'h00, alert_line}, {7'h00, exp});
	endtask
	task automatic meas(input logic [2:0] c, input logic [7:0] d);
		@(posedge i_core_clk);
		meas_valid <= 1'b1;
		meas_chan <= c;
		meas_data <= d;
		@(posedge i_core_clk);
		meas_valid <= 1'b0;
		repeat (3) @(posedge i_core_clk);
	endtask
	task automatic close_out();
		fail_count += host.stalls;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_reset();
		rd(8'h39, 8'h50);
		rd(8'h3A, 8'h41);
		rd(8'h2B, 8'hD3);
		rd(8'h32, 8'hAD);
		rd(8'h41, 8'h00);
		rd(8'h43, 8'h00);
		check({7'h00, monitor_run}, 8'h00);
		$display("reset values done");
	endtask
	task automatic t_volt();
		wr(8'h40, 8'h03);
		check({7'h00, monitor_run}, 8'h01);
		meas(3'h0, 8'h10);
		alert(1'b0);
		meas(3'h1, 8'hF0);
		rd(8'h41, 8'h03);
		clr();
		alert(1'b1);
		rd(8'h41, 8'h00);
		meas(3'h0, 8'h10);
		alert(1'b0);
		rd(8'h41, 8'h01);
		clr();
		$display("voltage limits done");
	endtask
	task automatic t_mask();
		wr(8'h43, 8'h01);
		meas(3'h0, 8'h10);
		alert(1'b1);
		rd(8'h41, 8'h00);
		wr(8'h43, 8'h00);
		wr(8'h40, 8'h01);
		meas(3'h2, 8'h10);
		alert(1'b1);
		rd(8'h41, 8'h04);
		clr();
		wr(8'h40, 8'h03);
		$display("mask and enable done");
	endtask
	task automatic t_temp();
		wr(8'h4C, 8'h02);
		meas(3'h4, 8'h60);
		alert(1'b0);
		rd(8'h24, 8'h60);
		rd(8'h41, 8'h10);
		clr();
		rd(8'h41, 8'h10);
		alert(1'b0);
		meas(3'h4, 8'h30);
		alert(1'b1);
		rd(8'h41, 8'h00);
		wr(8'h4C, 8'h03);
		meas(3'h4, 8'h60);
		rd(8'h41, 8'h10);
		clr();
		alert(1'b1);
		rd(8'h41, 8'h00);
		meas(3'h4, 8'h48);
		rd(8'h41, 8'h10);
		clr();
		wr(8'h4C, 8'h01);
		meas(3'h4, 8'h60);
		rd(8'h41, 8'h00);
		meas(3'h4, 8'h30);
		alert(1'b0);
		rd(8'h41, 8'h10);
		clr();
		meas(3'h4, 8'h30);
		rd(8'h41, 8'h00);
		$display("temperature modes done");
	endtask
	task automatic t_stop();
		meas(3'h0, 8'h10);
		wr(8'h40, 8'h0B);
		alert(1'b1);
		check({7'h00, monitor_run}, 8'h00);
		rd(8'h41, 8'h01);
		clr();
		wr(8'h40, 8'h02);
		meas(3'h3, 8'h10);
		rd(8'h41, 8'h00);
		rd(8'h23, 8'h10);
		wr(8'h40, 8'h30);
		check({6'h00, short_cycle, line_50hz}, 8'h03);
		check({7'h00, monitor_run}, 8'h00);
		wr(8'h39, 8'h70);
		rd(8'h39, 8'h70);
		wr(8'h2C, 8'h08);
		rd(8'h2C, 8'h08);
		wr(8'h40, 8'h80);
		rd(8'h39, 8'h50);
		rd(8'h2C, 8'hAD);
		rd(8'h40, 8'h00);
		$display("clear and shutdown done");
	endtask

	initial begin
		fail_count = 0;
		compares = 0;
		i_nrst = 1'b0;
		meas_valid = 1'b0;
		meas_chan = 3'h0;
		meas_data = 8'h00;
		repeat (5) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_link_clk);
		t_reset();
		t_volt();
		t_mask();
		t_temp();
		t_stop();
		close_out();
	end

	// About ten times the expected run length
	initial begin
		#50000;
		fail_count++;
		$display("BAD %0t watchdog expired", $time);
		close_out();
	end
endmodule
